// >>> rtl/beep_drc_pkg.sv
// Constants for the compressor rate and beep control register bank.
// Assumes an APB slave with 32-bit data and one register per word.
package beep_drc_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_DRC_RATES = 8'h46;
  localparam logic [7:0] IDX_BEEP_CTRL = 8'h47;
  localparam logic [7:0] IDX_RSVD = 8'h48;
  localparam logic [7:0] IDX_LEN_HI = 8'h49;
  localparam logic [7:0] IDX_LEN_MID = 8'h4a;
  localparam logic [7:0] IDX_LEN_LO = 8'h4b;
  localparam logic [7:0] IDX_SIN_HI = 8'h4c;
  localparam logic [7:0] IDX_SIN_LO = 8'h4d;
  localparam logic [7:0] IDX_COS_HI = 8'h4e;
  localparam logic [7:0] IDX_COS_LO = 8'h4f;
  localparam logic [7:0] IDX_MODE = 8'h3c;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_DRC_RATES = 8'h00;
  localparam logic [7:0] RST_BEEP_CTRL = 8'h00;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_LEN_HI = 8'h00;
  localparam logic [7:0] RST_LEN_MID = 8'h00;
  localparam logic [7:0] RST_LEN_LO = 8'hee;
  localparam logic [7:0] RST_SIN_HI = 8'h10;
  localparam logic [7:0] RST_SIN_LO = 8'hd8;
  localparam logic [7:0] RST_COS_HI = 8'h7e;
  localparam logic [7:0] RST_COS_LO = 8'he3;
  localparam logic [7:0] RST_MODE = 8'h01;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ATTACK_MSB = 7;
  localparam int ATTACK_LSB = 4;
  localparam int DECAY_MSB = 3;
  localparam int DECAY_LSB = 0;
  localparam int BEEP_EN_BIT = 7;
  localparam int BEEP_RSVD_BIT = 6;
  localparam int VOL_MSB = 5;
  localparam int VOL_LSB = 0;

  // ****************************************
  // Values and widths
  // ****************************************
  localparam logic [7:0] MODE_WITH_BEEP = 8'h19;
  localparam int RATE_W = 24;
  // Rates in dB per word clock, LSB of 2^-21 dB
  localparam logic [23:0] ATTACK_BASE = 24'h80_0000;
  localparam logic [23:0] DECAY_BASE = 24'h00_8000;
  localparam logic [6:0] BEEP_VOL_TOP = 7'h02;
  localparam int LEN_W = 24;
  localparam logic [31:0] PSLVERR_DATA = 32'h0000_0000;

endpackage

// >>> rtl/rate_shifter.sv
// Rate per word clock from a four-bit halving code.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/10ps
module rate_shifter #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] BASE = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] code_i,
  output logic [WIDTH-1:0] rate_o
);

  if (WIDTH < 16) begin : g_bad_width
    $error("rate_shifter needs at least 16 bits");
  end

  // ****************************************
  // Base rate halved once per code step
  // ****************************************
  wire [WIDTH-1:0] rate_d = BASE >> code_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_o <= '0;
    end else begin
      rate_o <= rate_d;
    end
  end

endmodule

// >>> rtl/beep_length_counter.sv
// Counts the beep duration down in DAC samples.
// Assumes start, abort, run and tick are on the same clock.
`timescale 1ns/10ps
module beep_length_counter
  import beep_drc_pkg::*;
#(
  parameter int WIDTH = LEN_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [WIDTH-1:0] length_i,
  output logic busy_o,
  output logic done_o
);

  if (WIDTH < 2) begin : g_bad_width
    $error("beep_length_counter needs at least 2 bits");
  end

  logic [WIDTH-1:0] count_q;

  // ****************************************
  // Load, count per sample, stop at zero
  // ****************************************
  wire step = busy_o & run_i & tick_i;
  wire last = (count_q <= WIDTH'(1));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i) begin
      count_q <= length_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (abort_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (step && last) begin
      count_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b1;
    end else if (step) begin
      count_q <= count_q - WIDTH'(1);
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule

// >>> rtl/beep_drc_regs.sv
// APB register bank for compressor rates and the beep generator.
// Assumes an APB master on clk_i and an asynchronous DAC word clock pin.
`timescale 1ns/10ps
module beep_drc_regs
  import beep_drc_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic dac_word_clock_i,
  output logic [RATE_W-1:0] attack_rate_o,
  output logic [RATE_W-1:0] decay_rate_o,
  output logic beep_active_o,
  output logic [6:0] beep_gain_db_o,
  output logic [15:0] beep_sin_coef_o,
  output logic [15:0] beep_cos_coef_o
);

  if (ADDR_WIDTH < 10) begin : g_bad_addr
    $error("beep_drc_regs needs at least 10 address bits");
  end

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] drc_rates_q;
  logic beep_en_q;
  logic beep_rsvd_q;
  logic [5:0] beep_vol_q;
  logic [7:0] rsvd_q;
  logic [7:0] len_hi_q;
  logic [7:0] len_mid_q;
  logic [7:0] len_lo_q;
  logic [7:0] sin_hi_q;
  logic [7:0] sin_lo_q;
  logic [7:0] cos_hi_q;
  logic [7:0] cos_lo_q;
  logic [7:0] dac_processing_mode_q;

  // ****************************************
  // Word clock synchroniser and edge
  // ****************************************
  logic wclk_meta_q;
  logic wclk_sync_q;
  logic wclk_prev_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wclk_meta_q <= 1'b0;
      wclk_sync_q <= 1'b0;
      wclk_prev_q <= 1'b0;
    end else begin
      wclk_meta_q <= dac_word_clock_i;
      wclk_sync_q <= wclk_meta_q;
      wclk_prev_q <= wclk_sync_q;
    end
  end

  wire sample_tick = wclk_sync_q & ~wclk_prev_q;

  // ****************************************
  // APB decode
  // ****************************************
  wire [ADDR_WIDTH-3:0] word_idx = paddr_i[ADDR_WIDTH-1:2];
  wire aligned = (paddr_i[1:0] == 2'b00);
  wire upper_zero = (word_idx >> 8) == '0;
  wire [7:0] idx = word_idx[7:0];
  wire idx_ok = aligned & upper_zero;

  wire hit_rates = idx_ok & (idx == IDX_DRC_RATES);
  wire hit_ctrl = idx_ok & (idx == IDX_BEEP_CTRL);
  wire hit_rsvd = idx_ok & (idx == IDX_RSVD);
  wire hit_len_hi = idx_ok & (idx == IDX_LEN_HI);
  wire hit_len_mid = idx_ok & (idx == IDX_LEN_MID);
  wire hit_len_lo = idx_ok & (idx == IDX_LEN_LO);
  wire hit_sin_hi = idx_ok & (idx == IDX_SIN_HI);
  wire hit_sin_lo = idx_ok & (idx == IDX_SIN_LO);
  wire hit_cos_hi = idx_ok & (idx == IDX_COS_HI);
  wire hit_cos_lo = idx_ok & (idx == IDX_COS_LO);
  wire hit_mode = idx_ok & (idx == IDX_MODE);

  wire hit_any = hit_rates | hit_ctrl | hit_rsvd | hit_len_hi
               | hit_len_mid | hit_len_lo | hit_sin_hi | hit_sin_lo
               | hit_cos_hi | hit_cos_lo | hit_mode;

  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i & pready_o;
  wire wr_lane = access & pwrite_i & pstrb_i[0] & hit_any;
  wire [7:0] wbyte = pwdata_i[7:0];

  wire wr_rates = wr_lane & hit_rates;
  wire wr_ctrl = wr_lane & hit_ctrl;
  wire wr_rsvd = wr_lane & hit_rsvd;
  wire wr_len_hi = wr_lane & hit_len_hi;
  wire wr_len_mid = wr_lane & hit_len_mid;
  wire wr_len_lo = wr_lane & hit_len_lo;
  wire wr_sin_hi = wr_lane & hit_sin_hi;
  wire wr_sin_lo = wr_lane & hit_sin_lo;
  wire wr_cos_hi = wr_lane & hit_cos_hi;
  wire wr_cos_lo = wr_lane & hit_cos_lo;
  wire wr_mode = wr_lane & hit_mode;

  // ****************************************
  // Read data selection
  // ****************************************
  wire [7:0] ctrl_view = {beep_en_q, beep_rsvd_q, beep_vol_q};

  wire [7:0] rd_byte =
      hit_rates ? drc_rates_q :
      hit_ctrl ? ctrl_view :
      hit_rsvd ? rsvd_q :
      hit_len_hi ? len_hi_q :
      hit_len_mid ? len_mid_q :
      hit_len_lo ? len_lo_q :
      hit_sin_hi ? sin_hi_q :
      hit_sin_lo ? sin_lo_q :
      hit_cos_hi ? cos_hi_q :
      hit_cos_lo ? cos_lo_q :
      hit_mode ? dac_processing_mode_q :
      8'h00;

  wire [31:0] rd_word = hit_any ? {24'h00_0000, rd_byte} : PSLVERR_DATA;

  // ****************************************
  // APB answer, one access cycle
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= ~hit_any;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_word;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Plain read-write registers
  // ****************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drc_rates_q <= RST_DRC_RATES;
    end else if (wr_rates) begin
      drc_rates_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsvd_q <= RST_RSVD;
    end else if (wr_rsvd) begin
      rsvd_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_hi_q <= RST_LEN_HI;
    end else if (wr_len_hi) begin
      len_hi_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_mid_q <= RST_LEN_MID;
    end else if (wr_len_mid) begin
      len_mid_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_lo_q <= RST_LEN_LO;
    end else if (wr_len_lo) begin
      len_lo_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sin_hi_q <= RST_SIN_HI;
    end else if (wr_sin_hi) begin
      sin_hi_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sin_lo_q <= RST_SIN_LO;
    end else if (wr_sin_lo) begin
      sin_lo_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cos_hi_q <= RST_COS_HI;
    end else if (wr_cos_hi) begin
      cos_hi_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cos_lo_q <= RST_COS_LO;
    end else if (wr_cos_lo) begin
      cos_lo_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_processing_mode_q <= RST_MODE;
    end else if (wr_mode) begin
      dac_processing_mode_q <= wbyte;
    end
  end

  // ****************************************
  // Compressor rates
  // ****************************************
  // Attack: 4 dB halved per code step
  rate_shifter #(
    .WIDTH(RATE_W),
    .BASE(ATTACK_BASE)
  ) u_attack (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .code_i(drc_rates_q[ATTACK_MSB:ATTACK_LSB]),
    .rate_o(attack_rate_o)
  );

  // Decay: base rate over two to the code
  rate_shifter #(
    .WIDTH(RATE_W),
    .BASE(DECAY_BASE)
  ) u_decay (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .code_i(drc_rates_q[DECAY_MSB:DECAY_LSB]),
    .rate_o(decay_rate_o)
  );

  // ****************************************
  // Beep control and duration
  // ****************************************
  logic beep_busy;
  logic beep_done;

  wire mode_has_beep = (dac_processing_mode_q == MODE_WITH_BEEP);
  wire set_en = wr_ctrl & wbyte[BEEP_EN_BIT];
  wire clr_en = wr_ctrl & ~wbyte[BEEP_EN_BIT];
  wire start_beep = set_en & (~beep_en_q | beep_done);
  wire [LEN_W-1:0] beep_length = {len_hi_q, len_mid_q, len_lo_q};

  // Set wins over the end-of-beep clear
  wire beep_en_d = set_en ? 1'b1 :
                   (clr_en | beep_done) ? 1'b0 :
                   beep_en_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      beep_en_q <= RST_BEEP_CTRL[BEEP_EN_BIT];
      beep_rsvd_q <= RST_BEEP_CTRL[BEEP_RSVD_BIT];
      beep_vol_q <= RST_BEEP_CTRL[VOL_MSB:VOL_LSB];
    end else begin
      beep_en_q <= beep_en_d;
      if (wr_ctrl) begin
        beep_rsvd_q <= wbyte[BEEP_RSVD_BIT];
        beep_vol_q <= wbyte[VOL_MSB:VOL_LSB];
      end
    end
  end

  beep_length_counter #(
    .WIDTH(LEN_W)
  ) u_length (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(start_beep),
    .abort_i(clr_en),
    .run_i(mode_has_beep),
    .tick_i(sample_tick),
    .length_i(beep_length),
    .busy_o(beep_busy),
    .done_o(beep_done)
  );

  // ****************************************
  // Beep outputs
  // ****************************************
  // Tone only with enable set and mode 25
  wire beep_active_d = beep_en_q & beep_busy & mode_has_beep;
  // Gain is 2 dB minus the volume code
  wire [6:0] beep_gain_d = BEEP_VOL_TOP - {1'b0, beep_vol_q};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      beep_active_o <= 1'b0;
      beep_gain_db_o <= BEEP_VOL_TOP;
      beep_sin_coef_o <= {RST_SIN_HI, RST_SIN_LO};
      beep_cos_coef_o <= {RST_COS_HI, RST_COS_LO};
    end else begin
      beep_active_o <= beep_active_d;
      beep_gain_db_o <= beep_gain_d;
      beep_sin_coef_o <= {sin_hi_q, sin_lo_q};
      beep_cos_coef_o <= {cos_hi_q, cos_lo_q};
    end
  end

endmodule

// >>> tb/beep_drc_regs_assertions.sv
// Checker for the compressor rate and beep register bank.
// Assumes it is bound to beep_drc_regs and sees its ports only.
`timescale 1ns/10ps
module beep_drc_regs_assertions
  import beep_drc_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [RATE_W-1:0] attack_rate_o,
  input wire logic [RATE_W-1:0] decay_rate_o,
  input wire logic beep_active_o,
  input wire logic [6:0] beep_gain_db_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire logic acc = psel_i && penable_i && pready_o;
  wire logic wr = acc && pwrite_i && pstrb_i[0];
  wire logic at_rates = paddr_i == {IDX_DRC_RATES, 2'b00};
  wire logic at_ctrl = paddr_i == {IDX_BEEP_CTRL, 2'b00};
  wire logic at_mode = paddr_i == {IDX_MODE, 2'b00};
  wire logic [3:0] attack_code = pwdata_i[ATTACK_MSB:ATTACK_LSB];
  wire logic [3:0] decay_code = pwdata_i[DECAY_MSB:DECAY_LSB];
  wire logic beep_cause = wr && (at_mode || at_ctrl && pwdata_i[BEEP_EN_BIT]);
  // ****************************************
  // Sequences and properties
  // ****************************************
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_ctrl_read;
    acc && !pwrite_i && at_ctrl;
  endsequence
  property p_ready_after_setup;
    s_setup |=> pready_o;
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_attack;
    wr && at_rates |-> ##2 attack_rate_o == (ATTACK_BASE >> $past(attack_code, 2));
  endproperty
  property p_decay;
    wr && at_rates |-> ##2 decay_rate_o == (DECAY_BASE >> $past(decay_code, 2));
  endproperty
  property p_gain;
    s_ctrl_read |-> beep_gain_db_o == BEEP_VOL_TOP - {1'b0, prdata_o[5:0]};
  endproperty
  property p_off_when_clear;
    s_ctrl_read ##0 !prdata_o[BEEP_EN_BIT] |=> !beep_active_o;
  endproperty
  property p_beep_cause;
    $rose(beep_active_o) |-> $past(beep_cause, 2);
  endproperty
  property p_err_zero;
    pslverr_o |-> pready_o && prdata_o == 32'h0000_0000;
  endproperty
  property p_rdata_top;
    pready_o |-> prdata_o[31:8] == 24'h00_0000;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  a_attack: assert property (p_attack) else $error("attack rate wrong");
  a_decay: assert property (p_decay) else $error("decay rate wrong");
  a_gain: assert property (p_gain) else $error("beep gain wrong");
  a_off_when_clear: assert property (p_off_when_clear) else $error("tone on");
  a_beep_cause: assert property (p_beep_cause) else $error("tone unasked");
  a_err_zero: assert property (p_err_zero) else $error("error data not zero");
  a_rdata_top: assert property (p_rdata_top) else $error("read upper bits set");
endmodule

// >>> tb/beep_drc_regs_tb_top.sv
// Self-checking bench for the compressor rate and beep register bank.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module beep_drc_regs_tb_top;
  import beep_drc_pkg::*;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [3:0] pstrb_i = '0;
  logic dac_word_clock_i = 0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, beep_active_o;
  logic [23:0] attack_rate_o, decay_rate_o, len;
  logic [6:0] beep_gain_db_o;
  logic [15:0] beep_sin_coef_o, beep_cos_coef_o;
  logic [31:0] rd;
  logic err;
  logic [7:0] v, a;
  logic [7:0] cf [4];
  logic [7:0] rst_v [10] = '{RST_DRC_RATES, RST_BEEP_CTRL, RST_RSVD, RST_LEN_HI, RST_LEN_MID,
    RST_LEN_LO, RST_SIN_HI, RST_SIN_LO, RST_COS_HI, RST_COS_LO};
  logic [23:0] lens [4] = '{24'h00_0000, 24'h00_0001, 24'h00_0000, 24'h00_0102};
  int num_errors = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  beep_drc_regs dut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .dac_word_clock_i, .attack_rate_o,
    .decay_rate_o, .beep_active_o, .beep_gain_db_o, .beep_sin_coef_o, .beep_cos_coef_o);
  // ****************************************
  // Tasks and functions
  // ****************************************
  function automatic logic [23:0] rate_of(input logic [23:0] base, input logic [3:0] c);
    return base >> c;
  endfunction
  function automatic logic [6:0] gain_of(input logic [5:0] g);
    return 7'h02 - {1'b0, g};
  endfunction
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    input logic [3:0] s = 4'hf, input logic [3:0] stray = 4'h0);
    int n;
    @(posedge clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= {stray[3:2], idx, stray[1:0]};
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) num_errors++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(0, idx, 0);
    chk("read data", {24'h00_0000, exp}, rd);
    chk("read error", 0, err);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i);
      dac_word_clock_i <= 1;
      repeat (4) @(posedge clk_i);
      dac_word_clock_i <= 0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #80000;
    num_errors++;
    results();
  end
  initial begin
    void'($urandom(47));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1;
    for (int i = 0; i < 10; i++) rchk(8'h46 + 8'(i), rst_v[i]);
    rchk(IDX_MODE, RST_MODE);
    chk("attack", ATTACK_BASE, attack_rate_o);
    chk("decay", DECAY_BASE, decay_rate_o);
    chk("coef", {RST_SIN_HI, RST_SIN_LO, RST_COS_HI, RST_COS_LO},
      {beep_sin_coef_o, beep_cos_coef_o});
    apb(1, 8'h50, 8'h11);
    chk("error", 1, err);
    apb(1, IDX_LEN_HI, 8'h5a, 4'h0);
    rchk(IDX_LEN_HI, 8'h00);
    apb(1, IDX_DRC_RATES, 8'hff, 4'hf, 4'h1);
    chk("unaligned error", 1, err);
    apb(1, IDX_DRC_RATES, 8'hff, 4'hf, 4'h4);
    chk("upper address error", 1, err);
    rchk(IDX_DRC_RATES, RST_DRC_RATES);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      v = {c[3:0], 4'($urandom)};
      apb(1, IDX_DRC_RATES, v);
      repeat (2) @(posedge clk_i);
      chk("attack", rate_of(ATTACK_BASE, v[7:4]), attack_rate_o);
      chk("decay", rate_of(DECAY_BASE, v[3:0]), decay_rate_o);
    end
    $display("test rates done");
    for (int g = 0; g < 64; g++) begin
      apb(1, IDX_BEEP_CTRL, g[5:0]);
      repeat (2) @(posedge clk_i);
      chk("gain", gain_of(g[5:0]), beep_gain_db_o);
      rchk(IDX_BEEP_CTRL, g[5:0]);
    end
    $display("test volume done");
    apb(1, IDX_LEN_LO, 8'h02);
    apb(1, IDX_BEEP_CTRL, 8'h80);
    ticks(3);
    chk("active", 0, beep_active_o);
    rchk(IDX_BEEP_CTRL, 8'h80);
    apb(1, IDX_BEEP_CTRL, 8'h00);
    apb(1, IDX_MODE, MODE_WITH_BEEP);
    $display("test mode done");
    for (int k = 0; k < 4; k++) begin
      len = (k == 2) ? 24'(2 + $urandom % 8) : lens[k];
      apb(1, IDX_LEN_MID, len[15:8]);
      apb(1, IDX_LEN_LO, len[7:0]);
      apb(1, IDX_BEEP_CTRL, 8'h80 | ($urandom % 64));
      repeat (2) @(posedge clk_i);
      chk("active", 1, beep_active_o);
      ticks((len == 0) ? 0 : len - 1);
      apb(0, IDX_BEEP_CTRL, 0);
      chk("enable", 1, rd[7]);
      chk("active", 1, beep_active_o);
      ticks(1);
      chk("active", 0, beep_active_o);
      apb(0, IDX_BEEP_CTRL, 0);
      chk("enable", 0, rd[7]);
    end
    apb(1, IDX_BEEP_CTRL, 8'h80);
    ticks(2);
    apb(1, IDX_BEEP_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("active", 0, beep_active_o);
    $display("test beep done");
    for (int r = 0; r < 24; r++) begin
      a = 8'h48 + 8'($urandom % 8);
      v = 8'($urandom);
      apb(1, a, v);
      rchk(a, v);
    end
    for (int j = 0; j < 4; j++) begin
      cf[j] = 8'($urandom);
      apb(1, IDX_SIN_HI + 8'(j), cf[j]);
    end
    repeat (2) @(posedge clk_i);
    chk("coef", {cf[0], cf[1], cf[2], cf[3]}, {beep_sin_coef_o, beep_cos_coef_o});
    $display("test storage done");
    results();
  end
endmodule
bind beep_drc_regs beep_drc_regs_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk_i, .reset_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
  .pslverr_o, .attack_rate_o, .decay_rate_o, .beep_active_o, .beep_gain_db_o);
